// ==== common/periph_lock_defs.svh ====
`ifndef PERIPH_LOCK_DEFS_SVH
`define PERIPH_LOCK_DEFS_SVH

// Geometry of the guarded peripheral space
`define GROUP_CNT      16
`define GROUP_IDX_W    4
`define PADDR_W        12
`define PDATA_W        32
`define KEY_W          8

// Unlock series, written in this order to the key register
`define KEY_FIRST      8'ha5
`define KEY_SECOND     8'hf1

// Key read value layout
`define KEY_STAT_OPEN  0
`define KEY_STAT_HALF  1
`define KEY_RD_ZERO    8'h00

// Guard bits come out of reset clear, so every peripheral is writable
`define GUARD_RST      16'h0000

`endif

// ==== common/periph_lock_pkg.sv ====
package periph_lock_pkg;

    // Key recognition states, one-hot
    typedef enum logic [2:0] {
        KEY_LOCKED = 3'b001,
        KEY_HALF   = 3'b010,
        KEY_OPEN   = 3'b100
    } keyState_t;

endpackage

// ==== verilog/guard_bit_store.sv ====
`include "periph_lock_defs.svh"

// Holds the guard bits; each bit is its own flop with a shared load strobe
module guard_bit_store (
    input  wire logic                  mclk,
    input  wire logic                  sys_rst,
    input  wire logic                  clkEn,
    input  wire logic                  wrEn,
    input  wire logic [`GROUP_CNT-1:0] wrData,
    output logic      [`GROUP_CNT-1:0] bits_r
);

    localparam logic [`GROUP_CNT-1:0] RST_VAL = `GUARD_RST;

    // One flop per group, loaded only when the key state allowed the write
    genvar gi;
    generate
        for (gi = 0; gi < `GROUP_CNT; gi = gi + 1) begin : g_bit
            always_ff @(posedge mclk or posedge sys_rst) begin
                if (sys_rst) begin
                    bits_r[gi] <= RST_VAL[gi];
                end else if (clkEn && wrEn) begin
                    bits_r[gi] <= wrData[gi];
                end
            end
        end
    endgenerate

endmodule

// ==== verilog/peripheral_register_lock.sv ====
`include "periph_lock_defs.svh"

module peripheral_register_lock
    import periph_lock_pkg::*;
(
    input  wire logic                    mclk,
    input  wire logic                    sys_rst,
    input  wire logic                    clkEn,
    input  wire logic                    keyWrStb,
    input  wire logic [`KEY_W-1:0]       keyWrData,
    input  wire logic                    keyRdStb,
    output logic      [`KEY_W-1:0]       keyRdData,
    output logic                         keyRdValid,
    input  wire logic                    guardWrStb,
    input  wire logic [`GROUP_CNT-1:0]   guardWrData,
    output logic      [`GROUP_CNT-1:0]   guardBits,
    output logic                         guardWrRejected,
    input  wire logic                    periphReqValid,
    input  wire logic                    periphReqWrite,
    input  wire logic [`GROUP_IDX_W-1:0] periphReqGroup,
    input  wire logic [`PADDR_W-1:0]     periphReqAddr,
    input  wire logic [`PDATA_W-1:0]     periphReqWdata,
    output logic                         periphFwdValid,
    output logic                         periphFwdWrite,
    output logic      [`GROUP_IDX_W-1:0] periphFwdGroup,
    output logic      [`PADDR_W-1:0]     periphFwdAddr,
    output logic      [`PDATA_W-1:0]     periphFwdWdata,
    output logic                         periphDropped
);

    keyState_t               keyState_r;
    keyState_t               keyState_nxt;
    logic [`GROUP_CNT-1:0]   guardBits_r;
    logic                    guardLoad;
    logic                    reqGuarded;
    logic [`KEY_W-1:0]       keyStatus;
    logic [`KEY_W-1:0]       keyRdData_r;
    logic                    keyRdValid_r;
    logic                    guardWrRejected_r;
    logic                    periphFwdValid_r;
    logic                    periphFwdWrite_r;
    logic [`GROUP_IDX_W-1:0] periphFwdGroup_r;
    logic [`PADDR_W-1:0]     periphFwdAddr_r;
    logic [`PDATA_W-1:0]     periphFwdWdata_r;
    logic                    periphDropped_r;

    // Key recognition; a mismatch falls back, but a first key still counts
    // series and restart
    always_comb begin
        keyState_nxt = keyState_r;
        if (keyWrStb) begin
            case (keyState_r)
                KEY_LOCKED: begin
                    keyState_nxt = (keyWrData == `KEY_FIRST) ? KEY_HALF : KEY_LOCKED;
                end
                KEY_HALF: begin
                    if (keyWrData == `KEY_SECOND) begin
                        keyState_nxt = KEY_OPEN;
                    end else if (keyWrData == `KEY_FIRST) begin
                        keyState_nxt = KEY_HALF;
                    end else begin
                        keyState_nxt = KEY_LOCKED;
                    end
                end
                KEY_OPEN: begin
                    keyState_nxt = KEY_LOCKED;
                end
                default: begin
                    keyState_nxt = KEY_LOCKED;
                end
            endcase
        end
    end

    // Key state register
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            keyState_r <= KEY_LOCKED;
        end else if (clkEn) begin
            keyState_r <= keyState_nxt;
        end
    end

    // The guard write is judged on the state before any key write of the same
    // cycle, so a relocking key write and a guard write together still land
    // open state gates guard writes
    assign guardLoad = guardWrStb && (keyState_r == KEY_OPEN);

    guard_bit_store u_store (
        .mclk    (mclk),
        .sys_rst (sys_rst),
        .clkEn   (clkEn),
        .wrEn    (guardLoad),
        .wrData  (guardWrData),
        .bits_r  (guardBits_r)
    );

    // Rejected guard write flagged for one cycle, nothing else happens
    // reject report
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            guardWrRejected_r <= 1'b0;
        end else if (clkEn) begin
            guardWrRejected_r <= guardWrStb && (keyState_r != KEY_OPEN);
        end
    end

    // Status word: open flag plus a half-way flag for debug
    always_comb begin
        keyStatus = `KEY_RD_ZERO;
        keyStatus[`KEY_STAT_OPEN] = (keyState_r == KEY_OPEN);
        keyStatus[`KEY_STAT_HALF] = (keyState_r == KEY_HALF);
    end

    // Key read answers one cycle after the strobe
    // report lock state
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            keyRdData_r  <= `KEY_RD_ZERO;
            keyRdValid_r <= 1'b0;
        end else if (clkEn) begin
            keyRdValid_r <= keyRdStb;
            if (keyRdStb) begin
                keyRdData_r <= keyStatus;
            end
        end
    end

    assign reqGuarded = guardBits_r[periphReqGroup];

    // Forward stage: reads always go through, guarded writes are swallowed
    // drop guarded writes
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            periphFwdValid_r <= 1'b0;
            periphDropped_r  <= 1'b0;
        end else if (clkEn) begin
            periphFwdValid_r <= periphReqValid && !(periphReqWrite && reqGuarded);
            periphDropped_r  <= periphReqValid && periphReqWrite && reqGuarded;
        end
    end

    // Payload flops; captured on every request, dropped writes included, so only the
    // cleared forward valid keeps a dropped write from reaching the peripheral's contents
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            periphFwdWrite_r <= 1'b0;
            periphFwdGroup_r <= '0;
            periphFwdAddr_r  <= '0;
            periphFwdWdata_r <= '0;
        end else if (clkEn && periphReqValid) begin
            periphFwdWrite_r <= periphReqWrite;
            periphFwdGroup_r <= periphReqGroup;
            periphFwdAddr_r  <= periphReqAddr;
            periphFwdWdata_r <= periphReqWdata;
        end
    end

    assign keyRdData       = keyRdData_r;
    assign keyRdValid      = keyRdValid_r;
    assign guardBits       = guardBits_r;
    assign guardWrRejected = guardWrRejected_r;
    assign periphFwdValid  = periphFwdValid_r;
    assign periphFwdWrite  = periphFwdWrite_r;
    assign periphFwdGroup  = periphFwdGroup_r;
    assign periphFwdAddr   = periphFwdAddr_r;
    assign periphFwdWdata  = periphFwdWdata_r;
    assign periphDropped   = periphDropped_r;

    // Checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    a_guard_locked_hold: assert property (
        (clkEn && keyState_r != KEY_OPEN) |=> guardBits == $past(guardBits)
    ) else $error("guard bits changed while locked");

    a_guard_open_load: assert property (
        (clkEn && guardWrStb && keyState_r == KEY_OPEN) |=> guardBits == $past(guardWrData)
    ) else $error("guard write lost while open");

    a_key_relock: assert property (
        (clkEn && keyWrStb && keyState_r == KEY_OPEN) |=> keyState_r == KEY_LOCKED
    ) else $error("key write did not relock");

    a_key_series: assert property (
        (clkEn && keyWrStb && keyWrData == `KEY_FIRST && keyState_r != KEY_OPEN)
        ##1 (clkEn && keyWrStb && keyWrData == `KEY_SECOND) |=> keyState_r == KEY_OPEN
    ) else $error("key series did not unlock");

    a_key_restart: assert property (
        (clkEn && keyWrStb && keyState_r == KEY_HALF && keyWrData != `KEY_SECOND
         && keyWrData != `KEY_FIRST) |=> keyState_r == KEY_LOCKED
    ) else $error("broken series not restarted");

    a_key_read_state: assert property (
        (clkEn && keyRdStb) |=> keyRdValid
            && keyRdData[`KEY_STAT_OPEN] == ($past(keyState_r) == KEY_OPEN)
    ) else $error("key read wrong state");

    a_write_dropped: assert property (
        (clkEn && periphReqValid && periphReqWrite && guardBits[periphReqGroup])
        |=> periphDropped && !periphFwdValid
    ) else $error("guarded write forwarded");

    a_read_passes: assert property (
        (clkEn && periphReqValid && !periphReqWrite)
        |=> periphFwdValid && !periphFwdWrite && periphFwdAddr == $past(periphReqAddr)
    ) else $error("read not forwarded");

    a_reject_flag: assert property (
        (clkEn && guardWrStb && keyState_r != KEY_OPEN) |=> guardWrRejected
    ) else $error("rejected guard write not flagged");

    c_unlock: cover property (keyState_r == KEY_HALF ##1 keyState_r == KEY_OPEN);
    c_guard_load: cover property (clkEn && guardLoad && |guardWrData);
    c_drop: cover property (periphDropped);
    c_relock: cover property (keyState_r == KEY_OPEN ##1 keyState_r == KEY_LOCKED);

endmodule

// ==== testbench/peripheral_register_lock_tb.sv ====
`include "periph_lock_defs.svh"

module peripheral_register_lock_tb;
    timeunit 1ns;
    timeprecision 100ps;

    logic                    mclk, sys_rst, clkEn;
    logic                    keyWrStb, keyRdStb, keyRdValid;
    logic [`KEY_W-1:0]       keyWrData, keyRdData;
    logic                    guardWrStb, guardWrRejected;
    logic [`GROUP_CNT-1:0]   guardWrData, guardBits;
    logic                    periphReqValid, periphReqWrite, periphFwdValid, periphFwdWrite, periphDropped;
    logic [`GROUP_IDX_W-1:0] periphReqGroup, periphFwdGroup;
    logic [`PADDR_W-1:0]     periphReqAddr, periphFwdAddr;
    logic [`PDATA_W-1:0]     periphReqWdata, periphFwdWdata;
    int                      num_errors = 0;
    int                      check_count = 0;
    integer                  seed = 32'h9d5d;
    int                      keySt = 0;
    logic [`GROUP_CNT-1:0]   guardExp = `GUARD_RST;

    peripheral_register_lock u_peripheral_register_lock (
        .mclk(mclk), .sys_rst(sys_rst), .clkEn(clkEn),
        .keyWrStb(keyWrStb), .keyWrData(keyWrData), .keyRdStb(keyRdStb),
        .keyRdData(keyRdData), .keyRdValid(keyRdValid),
        .guardWrStb(guardWrStb), .guardWrData(guardWrData), .guardBits(guardBits),
        .guardWrRejected(guardWrRejected), .periphReqValid(periphReqValid),
        .periphReqWrite(periphReqWrite), .periphReqGroup(periphReqGroup),
        .periphReqAddr(periphReqAddr), .periphReqWdata(periphReqWdata),
        .periphFwdValid(periphFwdValid), .periphFwdWrite(periphFwdWrite),
        .periphFwdGroup(periphFwdGroup), .periphFwdAddr(periphFwdAddr),
        .periphFwdWdata(periphFwdWdata), .periphDropped(periphDropped)
    );

    // Free-running 200 MHz clock
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    task automatic complete_run();
        if (num_errors == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic checkWord(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic checkFlag(input string what, input logic exp, input logic got);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("FAIL %s expected %b seen %b", what, exp, got);
        end
    endtask

    // Bench view of the key series: 0 locked, 1 first key seen, 2 open
    function automatic int nextKey(input int s, input logic [`KEY_W-1:0] d);
        if (s == 2) return 0;
        if (d == `KEY_FIRST) return 1;
        if (s == 1 && d == `KEY_SECOND) return 2;
        return 0;
    endfunction

    task automatic keyWr(input logic [`KEY_W-1:0] d);
        @(posedge mclk); #1;
        keyWrStb = 1'b1;
        keyWrData = d;
        @(posedge mclk); #1;
        keyWrStb = 1'b0;
        keyWrData = ~d;
        keySt = nextKey(keySt, d);
    endtask

    task automatic keyRd();
        logic [31:0] exp;
        exp = '0;
        exp[`KEY_STAT_OPEN] = (keySt == 2);
        exp[`KEY_STAT_HALF] = (keySt == 1);
        @(posedge mclk); #1;
        keyRdStb = 1'b1;
        @(posedge mclk); #1;
        keyRdStb = 1'b0;
        checkFlag("keyRdValid", 1'b1, keyRdValid); // read answered
        checkWord("keyRdData", exp, 32'(keyRdData)); // lock status
    endtask

    task automatic guardWr(input logic [`GROUP_CNT-1:0] d);
        @(posedge mclk); #1;
        guardWrStb = 1'b1;
        guardWrData = d;
        @(posedge mclk); #1;
        guardWrStb = 1'b0;
        guardWrData = ~d;
        if (keySt == 2) guardExp = d;
        checkFlag("guardWrRejected", keySt != 2, guardWrRejected); // refusal when not open
        checkWord("guardBits", 32'(guardExp), 32'(guardBits)); // guard contents
    endtask

    // One random firmware access; forwarding judged against the bench copy of the guards
    task automatic access();
        logic wr;
        logic [`GROUP_IDX_W-1:0] g;
        wr = 1'($random(seed));
        g = `GROUP_IDX_W'($random(seed));
        @(posedge mclk); #1;
        periphReqValid = 1'b1;
        periphReqWrite = wr;
        periphReqGroup = g;
        periphReqAddr = `PADDR_W'($random(seed));
        periphReqWdata = $random(seed);
        @(posedge mclk); #1;
        periphReqValid = 1'b0;
        checkFlag("periphFwdValid", !wr || !guardExp[g], periphFwdValid); // forward decision
        checkFlag("periphDropped", wr && guardExp[g], periphDropped); // write discard
        checkWord("periphFwdAddr", 32'(periphReqAddr), 32'(periphFwdAddr)); // address passes
        checkWord("periphFwdWdata", periphReqWdata, periphFwdWdata); // payload passes
        checkWord("periphFwdGroup", 32'({wr, g}), 32'({periphFwdWrite, periphFwdGroup})); // kind and group
    endtask

    // Watchdog sized well beyond the few hundred cycles the sequence needs
    initial begin
        #25000;
        num_errors++;
        complete_run();
    end

    initial begin
        logic [`GROUP_CNT-1:0] pat [4];
        pat = '{16'hffff, 16'h0000, 16'h0000, 16'h0000};
        {clkEn, keyWrStb, keyRdStb, guardWrStb, periphReqValid, periphReqWrite} = 6'b100000;
        {keyWrData, guardWrData, periphReqGroup, periphReqAddr, periphReqWdata} = '0;
        sys_rst = 1'b1;
        repeat (12) @(posedge mclk);
        #1;
        sys_rst = 1'b0;
        keyRd();
        guardWr(16'h0001);
        // Broken series must restart from the first key
        keyWr(`KEY_FIRST);
        keyRd();
        keyWr(8'h3c);
        keyRd();
        guardWr(16'h0002);
        for (int r = 0; r < 4; r++) begin
            if (r > 1) pat[r] = `GROUP_CNT'($random(seed));
            keyWr(`KEY_FIRST);
            keyWr(`KEY_FIRST);
            keyWr(`KEY_SECOND);
            keyRd();
            guardWr(pat[r]);
            guardWr(pat[r] ^ 16'h00f0);
            repeat (20) access();
            // Any key value relocks the open bank
            keyWr(`KEY_W'($random(seed)));
            keyRd();
            guardWr(~pat[r]);
            repeat (10) access();
        end
        // Enable low: key write, key read and request strobes are ignored; keyRdValid and periphFwdValid stay low
        @(posedge mclk); #1;
        clkEn = 1'b0;
        keyWrStb = 1'b1;
        keyWrData = `KEY_FIRST;
        keyRdStb = 1'b1;
        periphReqValid = 1'b1;
        periphReqWrite = 1'b0;
        @(posedge mclk); #1;
        keyWrStb = 1'b0;
        keyRdStb = 1'b0;
        periphReqValid = 1'b0;
        clkEn = 1'b1;
        checkFlag("keyRdValid", 1'b0, keyRdValid); // no answer while frozen
        checkFlag("periphFwdValid", 1'b0, periphFwdValid); // no forward while frozen
        keyRd(); // frozen key write not taken
        // Open the bank, load guards, then reset in mid-run
        keyWr(`KEY_FIRST);
        keyWr(`KEY_SECOND);
        guardWr(16'h0f0f);
        @(posedge mclk); #1;
        sys_rst = 1'b1;
        @(posedge mclk); #1;
        sys_rst = 1'b0;
        keySt = 0;
        guardExp = `GUARD_RST;
        checkWord("guardBits", 32'(guardExp), 32'(guardBits)); // guards back to reset value
        keyRd(); // locked after reset
        guardWr(16'h00ff); // refused after reset
        repeat (4) access();
        complete_run();
    end
endmodule
